/* File: hdl/lpsc_pkg.sv */
`default_nettype none
package lpsc_pkg;
  // Register byte offsets
  localparam logic [4:0] ADR_RCTL = 5'h00;
  localparam logic [4:0] ADR_MCTL = 5'h04;
  localparam logic [4:0] ADR_STAT = 5'h08;
  localparam logic [4:0] ADR_IST  = 5'h0c;
  localparam logic [4:0] ADR_IMSK = 5'h10;
  // regulator_control fields
  localparam int RC_RATE = 0;
  localparam int RC_VSEL = 4;
  localparam int RC_EN   = 8;
  localparam int RC_HOLD = 12;
  localparam int RC_BYP  = 13;
  localparam logic [1:0]  RATE_OFF = 2'h0;
  localparam logic [1:0]  RATE_RST = 2'h1;
  localparam logic [15:0] RCTL_RST = 16'h0081;
  // Mode control fields
  localparam int MC_DS  = 0;
  localparam int MC_BYP = 1;
  // Interrupt bits
  localparam int IRQ_RTC  = 0;
  localparam int IRQ_HIBW = 1;
  localparam int IRQ_RST  = 2;
  // Synchronised input indices; first four are hibernate wake sources
  localparam int W_CAN  = 0;
  localparam int W_GENW = 1;
  localparam int W_RTCW = 2;
  localparam int W_RST  = 3;
  localparam int W_RTCI = 4;
  localparam int W_SUP  = 5;
  // Supply target: base plus 50 mV per step
  localparam logic [11:0] VBASE_MV = 12'h02bc;
  localparam logic [11:0] VSTEP_MV = 12'h0032;
  // Core reset hold after supply is good
  localparam int CLK_MHZ      = 200;
  localparam int BOOT_HOLD_NS = 100;
  localparam int BOOT_CYC_I   = (BOOT_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] BOOT_CYC = 8'(BOOT_CYC_I);
  typedef enum logic [5:0] {
    ST_FULL = 6'h01,
    ST_ACT  = 6'h02,
    ST_DSLP = 6'h04,
    ST_HIB  = 6'h08,
    ST_RAMP = 6'h10,
    ST_BOOT = 6'h20
  } lpsc_mode_t;
endpackage
`default_nettype wire

/* File: hdl/lpsc_top.sv */
// Overview of operation
// - Deep sleep stops core and system clocks
// - Deep sleep blocks asynchronous peripheral access
// - Deep sleep exits only on reset/RTC
// - RTC interrupt in deep sleep enters active
// - Reset in deep sleep boots into full-on
// - Frequency field 00 enters hibernate
// - Hibernate three-states all external pins
// - Low general wake pin requests wake
// - Four wake sources, each separately enabled
// - Every hibernate wake restores regulator, resets
// - Only regulator control survives hibernate; its rate field returns to the reset rate
// - Hold bit set at hibernate entry keeps SDRAM clock enable low until cleared
// - Supply target set in 50 mV steps
// - Regulator may be disabled and bypassed
// - Full-on PLL used; active bypasses PLL
`default_nettype none
module lpsc_top
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        can_wake,
  input  wire logic        general_wake_pin_n,
  input  wire logic        rtc_wake,
  input  wire logic        rtc_irq,
  input  wire logic        reset_pin_n,
  input  wire logic        supply_ok,
  input  wire logic        sdram_cke_req,
  output logic             core_clock_en,
  output logic             sys_clock_en,
  output logic             pll_bypass,
  output logic             async_block,
  output logic             regulator_en,
  output logic             regulator_bypass,
  output logic      [11:0] supply_target_mv,
  output logic             core_rst_n,
  output logic             io_hiz,
  output logic             sdram_clock_enable_pin_o,
  output logic             sdram_clock_enable_pin_oe,
  output logic             irq
);
  import lpsc_pkg::*;

  typedef struct packed {
    lpsc_mode_t  mode;
    logic [15:0] rctl;
    logic        byp;
    logic [2:0]  ist;
    logic [2:0]  imsk;
    logic        hold;
    logic        from_hib;
    logic [7:0]  cnt;
    logic [11:0] tgt;
    logic        ack;
    logic [31:0] dat;
  } lpsc_top_st_t;

  lpsc_top_st_t st;
  lpsc_top_st_t nx;

  lpsc_wake_if w ();

  lpsc_wake u_wake
  (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .w       (w.syn)
  );

  // Gates ahead of the first flop only normalise polarity
  assign w.raw = {supply_ok, rtc_irq, ~reset_pin_n, rtc_wake, ~general_wake_pin_n, can_wake};
  assign w.wake_en = st.rctl[RC_EN +: 4];

  function automatic logic clocks_off(input lpsc_mode_t m);
    clocks_off = (m == ST_DSLP) || (m == ST_HIB) || (m == ST_RAMP);
  endfunction

  logic       bus_take;
  logic       bus_wr;
  logic       hib_req;
  logic       ds_req;
  logic [2:0] irq_set;
  logic [2:0] irq_w1c;

  assign bus_take = wb_cyc_i && wb_stb_i && !st.ack;
  // Writes commit on the ack edge, the one edge at which the master ends the cycle
  assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && st.ack;
  assign hib_req  = bus_wr && (wb_adr_i == ADR_RCTL) && wb_sel_i[0]
                    && (wb_dat_i[RC_RATE +: 2] == RATE_OFF);
  assign ds_req   = bus_wr && (wb_adr_i == ADR_MCTL) && wb_sel_i[0] && wb_dat_i[MC_DS];
  assign irq_w1c  = (bus_wr && (wb_adr_i == ADR_IST) && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;

  always_comb
  begin
    nx      = st;
    irq_set = 3'h0;
    nx.ack  = bus_take;
    if (bus_take)
    begin
      case (wb_adr_i)
        ADR_RCTL: nx.dat = {16'h0000, st.rctl};
        ADR_MCTL: nx.dat = {30'h0000_0000, st.byp, 1'b0};
        ADR_STAT: nx.dat = {16'h0000, w.lvl, st.from_hib, st.hold, 2'h0, st.mode};
        ADR_IST:  nx.dat = {29'h0000_0000, st.ist};
        ADR_IMSK: nx.dat = {29'h0000_0000, st.imsk};
        default:  nx.dat = 32'h0000_0000;
      endcase
    end
    if (bus_wr)
    begin
      case (wb_adr_i)
        ADR_RCTL:
        begin
          if (wb_sel_i[0])
            nx.rctl[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1])
            nx.rctl[15:8] = wb_dat_i[15:8];
        end
        ADR_MCTL:
        begin
          if (wb_sel_i[0])
            nx.byp = wb_dat_i[MC_BYP];
        end
        ADR_IMSK:
        begin
          if (wb_sel_i[0])
            nx.imsk = wb_dat_i[2:0];
        end
        default:
        begin
          nx.dat = nx.dat;
        end
      endcase
    end

    case (st.mode)
      ST_FULL, ST_ACT:
      begin
        if (hib_req)
          nx.mode = ST_HIB;
        else if (ds_req)
          nx.mode = ST_DSLP;
        else
          nx.mode = nx.byp ? ST_ACT : ST_FULL;
      end
      ST_DSLP:
      begin
        // Nothing but the RTC interrupt or reset leaves here
        if (w.lvl[W_RTCI])
        begin
          nx.mode = ST_ACT;
          nx.byp  = 1'b1;
          irq_set[IRQ_RTC] = 1'b1;
        end
      end
      ST_HIB:
      begin
        if (w.hib_wake)
        begin
          nx.mode     = ST_RAMP;
          nx.rctl[RC_RATE +: 2] = RATE_RST;
          nx.from_hib = 1'b1;
          // Only regulator control survives, with its rate field back at RATE_RST; the rest restarts clean
          nx.byp      = 1'b0;
          nx.imsk     = 3'h0;
          nx.ist      = 3'h0;
        end
      end
      ST_RAMP:
      begin
        if (w.lvl[W_SUP])
        begin
          nx.mode = ST_BOOT;
          nx.cnt  = 8'h00;
        end
      end
      ST_BOOT:
      begin
        if (st.cnt == BOOT_CYC - 8'h01)
        begin
          nx.mode     = ST_FULL;
          nx.from_hib = 1'b0;
          irq_set[st.from_hib ? IRQ_HIBW : IRQ_RST] = 1'b1;
        end
        else
          nx.cnt = st.cnt + 8'h01;
      end
      default:
      begin
        nx.mode = ST_FULL;
      end
    endcase

    // A flag set in the same cycle as its clear stays set
    nx.ist = (nx.ist & ~irq_w1c) | irq_set;

    // Reset pin acts as processor reset outside the hibernate path
    if (w.lvl[W_RST] && (st.mode != ST_HIB) && (st.mode != ST_RAMP))
    begin
      nx.mode = ST_BOOT;
      nx.cnt  = 8'h00;
      nx.byp  = 1'b0;
      nx.imsk = 3'h0;
      nx.ist  = 3'h0;
    end

    if ((nx.mode == ST_HIB) && (st.mode != ST_HIB))
      nx.hold = nx.rctl[RC_HOLD];
    else
      nx.hold = st.hold && nx.rctl[RC_HOLD];
    // Registered so the target never glitches while the field is rewritten
    nx.tgt = VBASE_MV + 12'(nx.rctl[RC_VSEL +: 4]) * VSTEP_MV;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st      <= '0;
      st.mode <= ST_FULL;
      st.rctl <= RCTL_RST;
      st.tgt  <= VBASE_MV + 12'(RCTL_RST[RC_VSEL +: 4]) * VSTEP_MV;
    end
    else if (ce)
      st <= nx;
  end

  assign wb_dat_o         = st.dat;
  assign wb_ack_o         = st.ack;
  assign core_clock_en    = !clocks_off(st.mode);
  assign sys_clock_en     = !clocks_off(st.mode);
  assign async_block      = clocks_off(st.mode);
  assign pll_bypass       = (st.mode == ST_ACT);
  assign regulator_bypass = st.rctl[RC_BYP];
  assign regulator_en     = !st.rctl[RC_BYP] && (st.mode != ST_HIB);
  assign supply_target_mv = st.tgt;
  assign core_rst_n       = (st.mode != ST_RAMP) && (st.mode != ST_BOOT);
  assign io_hiz           = (st.mode == ST_HIB);
  // Off in hibernate; the board pulldown holds the pin low meanwhile
  assign sdram_clock_enable_pin_oe = (st.mode != ST_HIB);
  assign sdram_clock_enable_pin_o  = st.hold ? 1'b0 : sdram_cke_req;
  assign irq              = |(st.ist & st.imsk);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  deep_sleep_clocks_a: assert property ((st.mode == ST_DSLP) |-> !core_clock_en && !sys_clock_en)
    else $error("clocks running in deep sleep");

  async_block_a: assert property ((st.mode == ST_DSLP) |-> async_block)
    else $error("async peripherals not blocked");

  ds_exit_cause_a: assert property (($past(st.mode) == ST_DSLP) && (st.mode != ST_DSLP)
    |-> $past(w.lvl[W_RTCI]) || $past(w.lvl[W_RST]))
    else $error("deep sleep left without cause");

  rtc_active_a: assert property ((st.mode == ST_DSLP) && w.lvl[W_RTCI] && !w.lvl[W_RST] && ce
    |=> (st.mode == ST_ACT) && pll_bypass && st.ist[IRQ_RTC])
    else $error("rtc wake did not enter active");

  reset_boot_a: assert property ((st.mode == ST_DSLP) && w.lvl[W_RST] && ce
    |=> (st.mode == ST_BOOT) && !core_rst_n)
    else $error("reset in deep sleep did not boot");

  hib_entry_a: assert property (hib_req && ce && !w.lvl[W_RST]
    && ((st.mode == ST_FULL) || (st.mode == ST_ACT))
    |=> (st.mode == ST_HIB) && !regulator_en && !core_clock_en)
    else $error("hibernate not entered");

  hib_pins_a: assert property ((st.mode == ST_HIB) |-> io_hiz && !sdram_clock_enable_pin_oe)
    else $error("pins driven in hibernate");

  hib_gate_a: assert property ((st.mode == ST_HIB) && ce && !(|(w.lvl[3:0] & st.rctl[RC_EN +: 4]))
    |=> (st.mode == ST_HIB))
    else $error("disabled source woke hibernate");

  hib_wake_a: assert property ((st.mode == ST_HIB) && ce && w.hib_wake
    |=> (st.mode == ST_RAMP) && regulator_en == !st.rctl[RC_BYP] && !core_rst_n)
    else $error("wake did not start reset sequence");

  retain_a: assert property ((st.mode == ST_HIB) && ce && w.hib_wake
    |=> st.rctl[15:2] == $past(st.rctl[15:2]) && st.imsk == 3'h0)
    else $error("retention wrong across hibernate");

  ramp_hold_a: assert property ((st.mode == ST_RAMP) |-> !core_rst_n && !core_clock_en)
    else $error("reset released before supply stable");

  cke_low_a: assert property (st.hold && (st.mode != ST_HIB)
    |-> sdram_clock_enable_pin_oe && !sdram_clock_enable_pin_o)
    else $error("sdram clock enable not held low");

  rtc_wake_c: cover property ((st.mode == ST_DSLP) ##1 (st.mode == ST_ACT));
  hib_cycle_c: cover property ((st.mode == ST_HIB) ##1 (st.mode == ST_RAMP) ##[1:80] (st.mode == ST_FULL));
  reset_exit_c: cover property ((st.mode == ST_DSLP) ##1 (st.mode == ST_BOOT));
  cke_hold_c: cover property (st.hold && (st.mode == ST_BOOT));
endmodule // lpsc_top
`default_nettype wire

/* File: hdl/lpsc_wake.sv */
`default_nettype none
module lpsc_wake
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic ce,
  lpsc_wake_if.syn  w
);
  import lpsc_pkg::*;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
  } lpsc_sync_t;

  lpsc_sync_t st;
  lpsc_sync_t nx;

  always_comb
  begin
    nx    = st;
    nx.s1 = w.raw;
    nx.s2 = st.s1;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else if (ce)
      st <= nx;
  end

  assign w.lvl      = st.s2;
  assign w.hib_wake = |(st.s2[W_RST:W_CAN] & w.wake_en);
endmodule // lpsc_wake
`default_nettype wire

/* File: hdl/lpsc_wake_if.sv */
`default_nettype none
interface lpsc_wake_if;
  logic [5:0] raw;
  logic [3:0] wake_en;
  logic [5:0] lvl;
  logic       hib_wake;
  modport ctl (output raw, output wake_en, input lvl, input hib_wake);
  modport syn (input raw, input wake_en, output lvl, output hib_wake);
endinterface
`default_nettype wire

/* File: verif/lpsc_partner.sv */
`default_nettype none
module lpsc_partner
(
  input  wire logic       clk_sys,
  input  wire logic [3:0] wreq,
  input  wire logic       rtc_int,
  input  wire logic [5:0] sup_dly,
  input  wire logic       regulator_en,
  input  wire logic       regulator_bypass,
  input  wire logic       cke_o,
  input  wire logic       cke_oe,
  output logic            can_wake,
  output logic            general_wake_pin_n,
  output logic            rtc_wake,
  output logic            rtc_irq,
  output logic            reset_pin_n,
  output logic            supply_ok,
  output logic            cke_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] ramp_reg = 6'h00;
  assign can_wake           = wreq[0];
  assign general_wake_pin_n = ~wreq[1]; // Any neighbour may pull it low
  assign rtc_wake           = wreq[2];
  assign reset_pin_n        = ~wreq[3];
  assign rtc_irq            = rtc_int;
  // Released pin falls to the board pulldown
  assign cke_pin = cke_oe ? cke_o : 1'b0;
  // Supply settles slowly; when bypassed it comes from outside
  always_ff @(posedge clk_sys)
  begin
    if (!regulator_en)
      ramp_reg <= 6'h00;
    else if (ramp_reg != sup_dly)
      ramp_reg <= ramp_reg + 6'h01;
  end
  assign supply_ok = regulator_bypass | (regulator_en && ramp_reg == sup_dly);
endmodule // lpsc_partner
`default_nettype wire

/* File: verif/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lpsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  logic [3:0] wreq = 4'h0;
  logic rtc_int = 1'b0;
  logic ce = 1'b1;
  logic [5:0] sup_dly = 6'h08;
  logic sdram_cke_req = 1'b0;
  logic wb_ack_o, can_wake, general_wake_pin_n, rtc_wake, rtc_irq, reset_pin_n, supply_ok, cke_pin;
  logic core_clock_en, sys_clock_en, pll_bypass, async_block, regulator_en, regulator_bypass;
  logic core_rst_n, io_hiz, sdram_clock_enable_pin_o, sdram_clock_enable_pin_oe, irq;
  logic [11:0] supply_target_mv;
  logic [31:0] rnd = 32'h0000_4d3b;
  logic [15:0] v;
  int err_count = 0;
  int checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  lpsc_top dut (.clk_sys, .rstn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .can_wake, .general_wake_pin_n, .rtc_wake, .rtc_irq, .reset_pin_n,
    .supply_ok, .sdram_cke_req, .core_clock_en, .sys_clock_en, .pll_bypass, .async_block, .regulator_en,
    .regulator_bypass, .supply_target_mv, .core_rst_n, .io_hiz, .sdram_clock_enable_pin_o,
    .sdram_clock_enable_pin_oe, .irq);
  lpsc_partner far (.clk_sys, .wreq, .rtc_int, .sup_dly, .regulator_en, .regulator_bypass,
    .cke_o(sdram_clock_enable_pin_o), .cke_oe(sdram_clock_enable_pin_oe), .can_wake,
    .general_wake_pin_n, .rtc_wake, .rtc_irq, .reset_pin_n, .supply_ok, .cke_pin);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction
  // Wake restores the default rate field; every other bit is retained
  function automatic logic [15:0] rctl_woke(input logic [15:0] r);
    return {r[15:2], RATE_RST};
  endfunction
  function automatic logic [31:0] mv(input logic [3:0] st);
    return {20'h0_0000, VBASE_MV + VSTEP_MV * {8'h00, st}};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
    if (n >= 50)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic wait_mode(input lpsc_mode_t m);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, ADR_STAT, 32'h0000_0000);
      n++;
    end
    while (q[5:0] !== m && n < 200);
    chk_word("mode", {26'h000_0000, m}, {26'h000_0000, q[5:0]});
    if (n >= 200)
      tally_and_finish();
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    wb(1'b0, ADR_RCTL, 32'h0000_0000);
    chk_word("rctl", {16'h0000, RCTL_RST}, q);
    chk_word("target", mv(4'h8), {20'h0_0000, supply_target_mv});
    wb(1'b0, 5'h14, 32'h0000_0000);
    chk_word("unmapped", 32'h0000_0000, q);
    wb(1'b1, ADR_MCTL, 32'h0000_0002);
    wait_mode(ST_ACT);
    chk_bit("pll_bypass", 1'b1, pll_bypass);
    wb(1'b1, ADR_MCTL, 32'h0000_0000);
    wait_mode(ST_FULL);
    chk_bit("pll_bypass", 1'b0, pll_bypass);
    $display("test modes done");
    wb(1'b1, ADR_MCTL, 32'h0000_0001);
    wait_mode(ST_DSLP);
    chk_bit("core_clk", 1'b0, core_clock_en);
    chk_bit("sys_clk", 1'b0, sys_clock_en);
    chk_bit("async_block", 1'b1, async_block);
    wreq <= 4'h7;
    repeat (12) @(posedge clk_sys);
    wait_mode(ST_DSLP);
    wreq <= 4'h0;
    wb(1'b1, ADR_IMSK, 32'h0000_0001);
    // Frozen enable must hold off even the RTC exit
    ce <= 1'b0;
    rtc_int <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk_bit("frozen_core_clk", 1'b0, core_clock_en);
    ce <= 1'b1;
    wait_mode(ST_ACT);
    rtc_int <= 1'b0;
    chk_bit("pll_bypass", 1'b1, pll_bypass);
    chk_bit("core_clk", 1'b1, core_clock_en);
    chk_bit("irq", 1'b1, irq);
    wb(1'b1, ADR_IMSK, 32'h0000_0000);
    chk_bit("irq_masked", 1'b0, irq);
    wb(1'b1, ADR_IST, 32'h0000_0001);
    wb(1'b0, ADR_IST, 32'h0000_0000);
    chk_word("ist", 32'h0000_0000, q);
    $display("test deep sleep rtc done");
    wb(1'b1, ADR_MCTL, 32'h0000_0001);
    wait_mode(ST_DSLP);
    wreq <= 4'h8;
    wait_mode(ST_BOOT);
    chk_bit("core_rst_n", 1'b0, core_rst_n);
    wreq <= 4'h0;
    wait_mode(ST_FULL);
    chk_bit("pll_bypass", 1'b0, pll_bypass);
    wb(1'b0, ADR_IST, 32'h0000_0000);
    chk_bit("ist_rst", 1'b1, q[IRQ_RST]);
    $display("test deep sleep reset done");
    wb(1'b1, ADR_RCTL, 32'h0000_2081);
    chk_bit("reg_bypass", 1'b1, regulator_bypass);
    chk_bit("reg_en", 1'b0, regulator_en);
    wb(1'b1, ADR_RCTL, 32'h0000_0081);
    $display("test bypass done");
    for (int s = 0; s < 4; s++)
    begin
      rnd = lfsr(rnd);
      sup_dly <= 6'h08 + {1'b0, rnd[20:16]};
      sdram_cke_req <= 1'b1;
      // Kept here to compare with what the device retains through hibernate
      v = {3'h0, rnd[12], 4'(1 << s), rnd[7:4], 4'h0};
      wb(1'b1, ADR_RCTL, {16'h0000, v});
      wait_mode(ST_HIB);
      chk_bit("reg_en", 1'b0, regulator_en);
      chk_bit("core_clk", 1'b0, core_clock_en);
      chk_bit("io_hiz", 1'b1, io_hiz);
      chk_bit("cke_pin", 1'b0, cke_pin);
      wreq <= 4'(1 << ((s + 1) % 4));
      repeat (12) @(posedge clk_sys);
      wait_mode(ST_HIB);
      wreq <= 4'(1 << s);
      wait_mode(ST_RAMP);
      wreq <= 4'h0;
      chk_bit("reg_en", 1'b1, regulator_en);
      chk_bit("core_rst_n", 1'b0, core_rst_n);
      wait_mode(ST_FULL);
      chk_bit("core_rst_n", 1'b1, core_rst_n);
      wb(1'b0, ADR_RCTL, 32'h0000_0000);
      chk_word("rctl", {16'h0000, rctl_woke(v)}, q);
      chk_word("target", mv(v[7:4]), {20'h0_0000, supply_target_mv});
      chk_bit("cke_pin", ~v[12], cke_pin);
      wb(1'b0, ADR_IST, 32'h0000_0000);
      chk_bit("ist_hib", 1'b1, q[IRQ_HIBW]);
      $display("test hibernate source %0d done", s);
    end
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
